// ### verilog/data_space_map.svh
// Offsets, field positions, reset values and limits of the data space decoder
`ifndef DATA_SPACE_MAP_SVH
`define DATA_SPACE_MAP_SVH
// Program space
`define FLASH_TOP_LARGE 16'h7fff
`define FLASH_TOP_SMALL 16'h3fff
`define LOCK_LARGE 16'h7bff
`define LOCK_SMALL 16'h3fff
// Data space
`define EXT_RAM_SIZE 16'h0800
`define IRAM_LOW_TOP 8'h7f
`define BANK_TOP 8'h1f
`define BIT_RAM_BASE 8'h20
`define BIT_RAM_TOP 8'h2f
`define SFR_BIT_MASK 8'hf8
// Special function registers kept here
`define SFR_PORT0 8'h80
`define SFR_PORT1 8'h90
`define SFR_PORT2 8'ha0
`define SFR_PORT3 8'hb0
`define SFR_STACK_PTR 8'h81
`define SFR_STATUS_WORD 8'hd0
`define SFR_CUR_PAGE 8'ha7
`define SFR_PAGE_CTRL 8'h84
`define SFR_STACK_MID 8'h85
`define SFR_STACK_BOT 8'h86
// Pages
`define PAGE_MAIN 8'h00
`define PAGE_CAN 8'h0c
`define PAGE_CFG 8'h0f
// Status word bank field
`define BANK_LSB 3
`define BANK_MSB 4
// Reset values
`define STACK_PTR_RESET 8'h07
`define AUTO_PAGE_RESET 1'b1
`define PAGE_RESET 8'h00
// Bus register offsets
`define REG_CTRL 32'h0000_0000
`define REG_PAGES 32'h0000_0004
`define REG_CORE 32'h0000_0008
`define CTRL_AUTO_BIT 0
`define CTRL_FLASHW_BIT 1
`endif

// ### verilog/data_space_pkg.sv
// Types shared by the data space decoder and its users
package data_space_pkg;
  typedef enum logic [2:0] {
    ACC_CODE = 3'b000,
    ACC_XDATA = 3'b001,
    ACC_DIRECT = 3'b010,
    ACC_INDIRECT = 3'b011,
    ACC_POINTER = 3'b100,
    ACC_PUSH = 3'b101,
    ACC_POP = 3'b110,
    ACC_IDLE = 3'b111
  } access_kind_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_IRAM = 3'b001,
    TGT_SFR = 3'b010,
    TGT_EXT_RAM = 3'b011,
    TGT_FLASH = 3'b100,
    TGT_FLASH_WRITE = 3'b101,
    TGT_LOCK = 3'b110,
    TGT_RESERVED = 3'b111
  } target_t;

  typedef struct packed {
    logic valid;
    access_kind_t kind;
    logic bit_op;
    logic write;
    logic ptr_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic valid;
    target_t target;
    logic is_bit;
    logic [2:0] bit_pos;
    logic [15:0] addr;
    logic [7:0] page;
    logic local_hit;
    logic [7:0] rdata;
  } core_rsp_t;
endpackage

// ### verilog/data_space_decode.sv
// Memory space decoder with stack pointer and paged special register stack
// Operation
// R1 - Flash spans from zero to 0x7fff, or to 0x3fff in small variant.
// R2 - Lock byte at 0x7bff or flash top; above 0x7bff reserved.
// R3 - Code reads hit flash; xdata hits extended RAM or flash writes.
// R4 - Data memory is 256 internal bytes plus 2048 extended bytes.
// R5 - Lower 128 bytes reachable by direct and indirect addressing.
// R6 - Above 0x7f, direct selects special registers, indirect upper RAM.
// R7 - Bytes 0x00-0x1f are four banks, one active by bank bits.
// R8 - Indirect pointer comes from register 0 or 1 of active bank.
// R9 - Bytes 0x20-0x2f hold bits 0x00-0x7f, eight per byte.
// R10 - Bit versus byte access chosen by instruction type only.
// R11 - Push writes stack pointer plus one, then increments the pointer.
// R12 - Reset sets stack pointer to 0x07.
// R13 - Special registers ending 0x0 or 0x8 are bit addressable.
// R14 - 256 pages by current page; only 0x00, 0x0c, 0x0f populated.
// R15 - Software selects page first, then accesses by direct addressing.
// R16 - Interrupt entry pushes page stack and loads interrupt page.
// R17 - Return pops stack; bottom then reads 0x00.
// R18 - Writes to stack levels never push or pop.
// R19 - Interrupt page is 0x00, or 0x0c for the CAN interrupt.
// R20 - Auto-page enable resets set; cleared leaves pages untouched.
// R21 - All-page registers decode whatever the current page.
// R22 - Software avoids unoccupied special register addresses.
// R23 - Bank n covers RAM 8n to 8n+7.
// R24 - Auto-page enable is bit 0 at 0x84 page 0x0f.
// R25 - Current page at 0xa7, all pages, resets to zero.
// R26 - Third nested push discards bottom level without warning.
`timescale 1ns/1ps
`include "data_space_map.svh"
module data_space_decode
  import data_space_pkg::*;
#(
  parameter bit LARGE_FLASH = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core access and interrupt events
  input wire core_req_t core_req,
  input wire logic irq_enter,
  input wire logic irq_is_can,
  input wire logic irq_return,
  // Decoded answer
  output core_rsp_t core_rsp
);
  logic [7:0] current_page_reg;
  logic [7:0] page_stack_middle;
  logic [7:0] page_stack_bottom;
  logic auto_page_enable;
  logic flash_write_mode;
  logic [7:0] stack_pointer;
  logic [1:0] bank_select_field;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic axi_wr;
  logic axi_wr_ok;
  logic core_sfr_wr;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_rdata;
  logic sfr_local;
  logic sfr_all_pages;
  core_rsp_t next_rsp;
  logic [7:0] next_stack_ptr;
  logic [15:0] flash_top;
  logic [15:0] lock_addr;

  assign flash_top = LARGE_FLASH ? `FLASH_TOP_LARGE : `FLASH_TOP_SMALL;
  assign lock_addr = LARGE_FLASH ? `LOCK_LARGE : `LOCK_SMALL;

  // Bus write channel acceptance
  assign axi_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign axi_wr_ok = (aw_addr == `REG_CTRL) || (aw_addr == `REG_PAGES) ||
                     (aw_addr == `REG_CORE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr <= {s_axi_awaddr[31:2], 2'b00};
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, error on unmapped offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (axi_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= axi_wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Bus read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case ({s_axi_araddr[31:2], 2'b00})
        `REG_CTRL: s_axi_rdata <= {30'h0, flash_write_mode,
                                   auto_page_enable};
        `REG_PAGES: s_axi_rdata <= {8'h00, page_stack_bottom,
                                    page_stack_middle, current_page_reg};
        `REG_CORE: s_axi_rdata <= {22'h0, bank_select_field, stack_pointer};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Special register view for direct core accesses
  assign sfr_addr = core_req.bit_op ?
                    (core_req.addr[7:0] & `SFR_BIT_MASK) : core_req.addr[7:0];
  // R21 all-page decode
  assign sfr_all_pages = (sfr_addr == `SFR_PORT0) ||
                         (sfr_addr == `SFR_PORT1) ||
                         (sfr_addr == `SFR_PORT2) ||
                         (sfr_addr == `SFR_PORT3) ||
                         (sfr_addr == `SFR_STACK_PTR) ||
                         (sfr_addr == `SFR_STATUS_WORD) ||
                         (sfr_addr == `SFR_CUR_PAGE);

  always_comb begin
    sfr_local = 1'b1;
    sfr_rdata = 8'h00;
    case (sfr_addr)
      `SFR_CUR_PAGE: sfr_rdata = current_page_reg;
      `SFR_STACK_PTR: sfr_rdata = stack_pointer;
      `SFR_STATUS_WORD: sfr_rdata = {3'b000, bank_select_field, 3'b000};
      default: sfr_local = 1'b0;
    endcase
    // R24 control bit and page stack levels on configuration page
    if (current_page_reg == `PAGE_CFG) begin
      case (sfr_addr)
        `SFR_PAGE_CTRL: begin
          sfr_local = 1'b1;
          sfr_rdata = {7'h00, auto_page_enable};
        end
        `SFR_STACK_MID: begin
          sfr_local = 1'b1;
          sfr_rdata = page_stack_middle;
        end
        `SFR_STACK_BOT: begin
          sfr_local = 1'b1;
          sfr_rdata = page_stack_bottom;
        end
        default: ;
      endcase
    end
  end

  assign core_sfr_wr = core_req.valid && core_req.write &&
                       !core_req.bit_op && core_req.kind == ACC_DIRECT &&
                       core_req.addr[7] && sfr_local;

  // Decoder for every access kind
  always_comb begin
    next_rsp = '0;
    next_stack_ptr = stack_pointer;
    next_rsp.valid = core_req.valid && core_req.kind != ACC_IDLE;
    next_rsp.page = current_page_reg;
    next_rsp.addr = core_req.addr;
    if (core_req.valid) begin
      case (core_req.kind)
        // R1 R2 program space map
        ACC_CODE: begin
          if (core_req.addr == lock_addr)
            next_rsp.target = TGT_LOCK;
          else if (LARGE_FLASH && core_req.addr > `LOCK_LARGE)
            next_rsp.target = TGT_RESERVED;
          else if (core_req.addr <= flash_top)
            next_rsp.target = TGT_FLASH;
          else
            next_rsp.target = TGT_RESERVED;
        end
        // R3 R4 extended data space
        ACC_XDATA: begin
          if (core_req.write && flash_write_mode)
            next_rsp.target = core_req.addr <= flash_top ?
                              TGT_FLASH_WRITE : TGT_RESERVED;
          else if (core_req.addr < `EXT_RAM_SIZE)
            next_rsp.target = TGT_EXT_RAM;
          else
            next_rsp.target = TGT_NONE;
        end
        ACC_DIRECT: begin
          // R10 bit access chosen by operand type
          next_rsp.is_bit = core_req.bit_op;
          next_rsp.addr = {8'h00, core_req.addr[7:0]};
          if (core_req.bit_op) begin
            next_rsp.bit_pos = core_req.addr[2:0];
            // R9 bit address to byte in bit RAM
            if (!core_req.addr[7])
              next_rsp.addr = {8'h00, `BIT_RAM_BASE + {4'h0,
                               core_req.addr[6:3]}};
            else
              // R13 only x0 and x8 registers hold bits
              next_rsp.addr = {8'h00, sfr_addr};
          end
          // R5 R6 direct low RAM, high special registers
          if (!core_req.addr[7]) begin
            next_rsp.target = TGT_IRAM;
          end else begin
            next_rsp.local_hit = sfr_local;
            next_rsp.rdata = sfr_rdata;
            // R14 unpopulated pages reserved
            if (sfr_all_pages || current_page_reg == `PAGE_MAIN ||
                current_page_reg == `PAGE_CAN ||
                current_page_reg == `PAGE_CFG)
              next_rsp.target = TGT_SFR;
            else
              next_rsp.target = TGT_RESERVED;
            if (sfr_all_pages)
              next_rsp.page = `PAGE_MAIN;
          end
        end
        // R6 indirect always reaches RAM
        ACC_INDIRECT: begin
          next_rsp.target = TGT_IRAM;
          next_rsp.addr = {8'h00, core_req.addr[7:0]};
        end
        // R8 R23 pointer register in active bank
        ACC_POINTER: begin
          next_rsp.target = TGT_IRAM;
          next_rsp.addr = {8'h00, 3'b000, bank_select_field, 2'b00,
                           core_req.ptr_sel};
        end
        // R11 push to pointer plus one
        ACC_PUSH: begin
          next_stack_ptr = stack_pointer + 8'h01;
          next_rsp.target = TGT_IRAM;
          next_rsp.addr = {8'h00, next_stack_ptr};
        end
        ACC_POP: begin
          next_stack_ptr = stack_pointer - 8'h01;
          next_rsp.target = TGT_IRAM;
          next_rsp.addr = {8'h00, stack_pointer};
        end
        default: next_rsp.target = TGT_NONE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      core_rsp <= '0;
    else
      core_rsp <= next_rsp;
  end

  // R12 stack pointer reset and update
  always_ff @(posedge aclk) begin
    if (!aresetn)
      stack_pointer <= `STACK_PTR_RESET;
    else if (core_req.valid &&
             (core_req.kind == ACC_PUSH || core_req.kind == ACC_POP))
      stack_pointer <= next_stack_ptr;
    else if (core_sfr_wr && sfr_addr == `SFR_STACK_PTR)
      stack_pointer <= core_req.wdata;
    else if (axi_wr && aw_addr == `REG_CORE && w_strb[0])
      stack_pointer <= w_data[7:0];
  end

  // R7 bank select field
  always_ff @(posedge aclk) begin
    if (!aresetn)
      bank_select_field <= 2'b00;
    else if (core_sfr_wr && sfr_addr == `SFR_STATUS_WORD)
      bank_select_field <= core_req.wdata[`BANK_MSB:`BANK_LSB];
    else if (axi_wr && aw_addr == `REG_CORE && w_strb[1])
      bank_select_field <= w_data[9:8];
  end

  // R20 R24 auto-page enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_page_enable <= `AUTO_PAGE_RESET;
      flash_write_mode <= 1'b0;
    end else if (core_sfr_wr && sfr_addr == `SFR_PAGE_CTRL) begin
      auto_page_enable <= core_req.wdata[0];
    end else if (axi_wr && aw_addr == `REG_CTRL && w_strb[0]) begin
      auto_page_enable <= w_data[`CTRL_AUTO_BIT];
      flash_write_mode <= w_data[`CTRL_FLASHW_BIT];
    end
  end

  // R25 page stack reset and shifting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_page_reg <= `PAGE_RESET;
      page_stack_middle <= `PAGE_RESET;
      page_stack_bottom <= `PAGE_RESET;
    end else if (irq_enter && auto_page_enable) begin
      // R16 R26 push, bottom value lost
      page_stack_bottom <= page_stack_middle;
      page_stack_middle <= current_page_reg;
      // R19 interrupt page choice
      current_page_reg <= irq_is_can ? `PAGE_CAN : `PAGE_MAIN;
    end else if (irq_return && auto_page_enable) begin
      // R17 pop, bottom empties to zero
      current_page_reg <= page_stack_middle;
      page_stack_middle <= page_stack_bottom;
      page_stack_bottom <= `PAGE_RESET;
    end else if (core_sfr_wr) begin
      // R18 R15 level writes without shifting
      if (sfr_addr == `SFR_CUR_PAGE)
        current_page_reg <= core_req.wdata;
      if (sfr_addr == `SFR_STACK_MID)
        page_stack_middle <= core_req.wdata;
      if (sfr_addr == `SFR_STACK_BOT)
        page_stack_bottom <= core_req.wdata;
    end else if (axi_wr && aw_addr == `REG_PAGES) begin
      if (w_strb[0])
        current_page_reg <= w_data[7:0];
      if (w_strb[1])
        page_stack_middle <= w_data[15:8];
      if (w_strb[2])
        page_stack_bottom <= w_data[23:16];
    end
  end
endmodule

// ### tb/data_space_decode_properties.sv
// Checker for decoder answers to core requests
`timescale 1ns/1ps
module data_space_decode_properties
  import data_space_pkg::*;
#(
  parameter bit LARGE_FLASH = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  input wire core_req_t core_req,
  input wire core_rsp_t core_rsp
);
  localparam logic [15:0] LOCK = LARGE_FLASH ? 16'h7bff : 16'h3fff;
  logic dv;
  logic psh;
  logic pop;
  assign dv = core_req.valid && core_req.kind == ACC_DIRECT;
  assign psh = core_req.valid && core_req.kind == ACC_PUSH;
  assign pop = core_req.valid && core_req.kind == ACC_POP;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_low_direct: assert property (
    dv && !core_req.bit_op && !core_req.addr[7] |=>
    core_rsp.target == TGT_IRAM && core_rsp.addr == $past(core_req.addr))
    else $error("low direct byte not in internal ram");
  a_upper_indirect: assert property (
    core_req.valid && core_req.kind == ACC_INDIRECT |=>
    core_rsp.target == TGT_IRAM &&
    core_rsp.addr[7:0] == $past(core_req.addr[7:0]))
    else $error("indirect access not in internal ram");
  a_bit_ram_map: assert property (
    dv && core_req.bit_op && !core_req.addr[7] |=> core_rsp.is_bit &&
    core_rsp.addr == 16'h0020 + $past(core_req.addr[6:3]) &&
    core_rsp.bit_pos == $past(core_req.addr[2:0]))
    else $error("bit address mapped wrongly");
  a_byte_not_bit: assert property (
    dv && !core_req.bit_op |=> !core_rsp.is_bit)
    else $error("byte access marked as bit");
  a_sfr_bit_base: assert property (
    dv && core_req.bit_op && core_req.addr[7] |=> core_rsp.is_bit &&
    core_rsp.addr[7:0] == ($past(core_req.addr[7:0]) & 8'hf8))
    else $error("special register bit base wrong");
  a_lock_byte: assert property (
    core_req.valid && core_req.kind == ACC_CODE && core_req.addr == LOCK
    |=> core_rsp.target == TGT_LOCK)
    else $error("lock byte not decoded");
  a_push_step: assert property (
    psh ##1 psh |=> core_rsp.addr[7:0] == $past(core_rsp.addr[7:0]) + 8'h01)
    else $error("push did not advance by one");
  a_pop_matches: assert property (
    psh ##1 pop |=> core_rsp.addr == $past(core_rsp.addr))
    else $error("pop did not read last push");
  a_ext_ram_window: assert property (
    core_req.valid && core_req.kind == ACC_XDATA && !core_req.write &&
    core_req.addr < 16'h0800 |=> core_rsp.target == TGT_EXT_RAM)
    else $error("extended ram read not decoded");
endmodule

bind data_space_decode data_space_decode_properties #(
  .LARGE_FLASH(LARGE_FLASH)
) chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .core_req(core_req),
  .core_rsp(core_rsp)
);

// ### tb/core_model.sv
// Core stand-in issuing decoder requests and interrupt events
`timescale 1ns/1ps
module core_model
  import data_space_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Decoder answer
  input wire core_rsp_t core_rsp,
  // Requests and events
  output core_req_t core_req,
  output logic irq_enter,
  output logic irq_is_can,
  output logic irq_return
);
  core_rsp_t rsps[$];
  initial begin
    core_req = '0;
    irq_enter = 1'b0;
    irq_is_can = 1'b0;
    irq_return = 1'b0;
  end
  // issues only the sequence it is given
  task automatic run(input core_req_t q[$]);
    rsps = {};
    foreach (q[i]) begin
      @(posedge aclk);
      core_req <= q[i];
      if (i > 0) begin
        #1 rsps.push_back(core_rsp);
      end
    end
    @(posedge aclk);
    core_req <= '0;
    #1 rsps.push_back(core_rsp);
  endtask
  task automatic irq(input logic en, input logic can, input logic ret);
    @(posedge aclk);
    irq_enter <= en;
    irq_is_can <= can;
    irq_return <= ret;
    @(posedge aclk);
    irq_enter <= 1'b0;
    irq_is_can <= 1'b0;
    irq_return <= 1'b0;
  endtask
endmodule

// ### tb/data_space_decode_tb_top.sv
// Self-checking bench for the data space decoder
`timescale 1ns/1ps
`include "data_space_map.svh"
module data_space_decode_tb_top
  import data_space_pkg::*;
;
  logic aclk, aresetn, awv, wv, bv, bre, arv, rv, rre, awr, wr, arr;
  logic [31:0] awa, wd, ara, rd, v;
  logic [1:0] br, rr, r;
  logic [2:0] prot;
  logic [3:0] strb;
  logic ie, ic, ir;
  core_req_t req;
  core_rsp_t rsp, o;
  int miscompares, cmp_count;
  logic [15:0] ca[5] = '{16'h0, 16'h7bfe, 16'h7bff, 16'h7c00, 16'hffff};
  target_t ct[5] = '{TGT_FLASH, TGT_FLASH, TGT_LOCK, TGT_RESERVED,
    TGT_RESERVED};

  data_space_decode #(.LARGE_FLASH(1'b1)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(prot), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .core_req(req), .irq_enter(ie),
    .irq_is_can(ic), .irq_return(ir), .core_rsp(rsp));
  core_model core_u (.aclk(aclk), .core_rsp(rsp), .core_req(req),
    .irq_enter(ie), .irq_is_can(ic), .irq_return(ir));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    r = br;
    bre <= 1'b0;
  endtask
  task automatic rd32(input logic [31:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rd;
    r = rr;
    rre <= 1'b0;
  endtask
  function automatic core_req_t rq(access_kind_t k, logic [15:0] a,
    logic b = 1'b0, logic w = 1'b0, logic [7:0] d = 8'h00, logic p = 1'b0);
    return {1'b1, k, b, w, p, a, d};
  endfunction
  task automatic one(input core_req_t q, input target_t t);
    core_u.run('{q});
    o = core_u.rsps[0];
    check(o.valid, 1'b1);
    check(o.target, t);
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    final_report();
  end
  initial begin
    {aresetn, awv, wv, bre, arv, rre, awa, wd, ara} = '0;
    prot = 3'h0;
    strb = 4'hf;
    miscompares = 0;
    cmp_count = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    core_u.run('{rq(ACC_PUSH, 16'h0), rq(ACC_PUSH, 16'h0),
      rq(ACC_POP, 16'h0)});
    check(core_u.rsps[0].addr, 32'h8);
    check(core_u.rsps[1].addr, 32'h9);
    check(core_u.rsps[2].addr, 32'h9);
    rd32(`REG_CORE);
    check(v, 32'h8);
    rd32(`REG_CTRL);
    check(v, 32'h1);
    rd32(`REG_PAGES);
    check(v, 32'h0);
    rd32(32'h10);
    check(r, 2'b10);
    wr32(32'h10, 32'h0);
    check(r, 2'b10);
    for (int i = 0; i < 5; i++) begin
      one(rq(ACC_CODE, ca[i]), ct[i]);
    end
    one(rq(ACC_XDATA, 16'h07ff), TGT_EXT_RAM);
    one(rq(ACC_XDATA, 16'h0800), TGT_NONE);
    wr32(`REG_CTRL, 32'h3);
    one(rq(ACC_XDATA, 16'h1000, 1'b0, 1'b1), TGT_FLASH_WRITE);
    one(rq(ACC_XDATA, 16'h0010), TGT_EXT_RAM);
    one(rq(ACC_CODE, 16'h1000), TGT_FLASH);
    wr32(`REG_CTRL, 32'h1);
    one(rq(ACC_DIRECT, 16'h7f), TGT_IRAM);
    one(rq(ACC_INDIRECT, 16'h7f), TGT_IRAM);
    one(rq(ACC_INDIRECT, 16'h80), TGT_IRAM);
    check(o.addr, 32'h80);
    one(rq(ACC_DIRECT, 16'h80), TGT_SFR);
    one(rq(ACC_DIRECT, 16'h13, 1'b1), TGT_IRAM);
    check({o.is_bit, o.addr, o.bit_pos}, {1'b1, 16'h22, 3'h3});
    one(rq(ACC_DIRECT, 16'h13), TGT_IRAM);
    check({o.is_bit, o.addr}, {1'b0, 16'h13});
    one(rq(ACC_DIRECT, 16'hd3, 1'b1), TGT_SFR);
    check({o.is_bit, o.addr, o.bit_pos}, {1'b1, 16'hd0, 3'h3});
    for (int n = 0; n < 4; n++) begin
      core_u.run('{rq(ACC_DIRECT, 16'hd0, 1'b0, 1'b1, 8'(n << 3)),
        rq(ACC_POINTER, 16'h0, 1'b0, 1'b0, 8'h0, 1'b1)});
      check(core_u.rsps[1].addr, 32'(8 * n + 1));
    end
    // page chosen first, then direct access
    core_u.run('{rq(ACC_DIRECT, 16'ha7, 1'b0, 1'b1, 8'h05),
      rq(ACC_DIRECT, 16'h91), rq(ACC_DIRECT, 16'h90),
      rq(ACC_DIRECT, 16'ha7)});
    check(core_u.rsps[1].target, TGT_RESERVED);
    o = core_u.rsps[2];
    check({o.target, o.page}, {TGT_SFR, 8'h0});
    o = core_u.rsps[3];
    check({o.local_hit, o.rdata}, 9'h105);
    core_u.run('{rq(ACC_DIRECT, 16'ha7, 1'b0, 1'b1, 8'h0c),
      rq(ACC_DIRECT, 16'h91)});
    o = core_u.rsps[1];
    check({o.target, o.page}, {TGT_SFR, 8'h0c});
    wr32(`REG_PAGES, 32'h0033220c);
    check(r, 2'b00);
    rd32(`REG_PAGES);
    check(v, 32'h0033220c);
    core_u.irq(1'b1, 1'b1, 1'b0);
    rd32(`REG_PAGES);
    check(v, 32'h00220c0c);
    core_u.irq(1'b1, 1'b0, 1'b0);
    rd32(`REG_PAGES);
    check(v, 32'h000c0c00);
    core_u.irq(1'b0, 1'b0, 1'b1);
    rd32(`REG_PAGES);
    check(v, 32'h00000c0c);
    core_u.irq(1'b0, 1'b0, 1'b1);
    rd32(`REG_PAGES);
    check(v, 32'h0000000c);
    wr32(`REG_CTRL, 32'h0);
    core_u.irq(1'b1, 1'b1, 1'b0);
    rd32(`REG_PAGES);
    check(v, 32'h0000000c);
    wr32(`REG_CTRL, 32'h1);
    core_u.run('{rq(ACC_DIRECT, 16'ha7, 1'b0, 1'b1, 8'h0f),
      rq(ACC_DIRECT, 16'h84)});
    check(core_u.rsps[1].rdata, 8'h01);
    final_report();
  end
endmodule
